// ==== common/sccr_cfg.svh ====
/*
  Offsets, field positions, reset values and timing counts of the SCSI
  control and configuration register bank.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef SCCR_CFG_SVH
`define SCCR_CFG_SVH

// Byte addresses (Wishbone, one 32-bit word per register)
`define SCCR_CTL_ADDR      8'h00
`define SCCR_CNF_ADDR      8'h04
`define SCCR_STS_ADDR      8'h08
`define SCCR_SET_ADDR      8'h0C
// Printed register indices
`define SCCR_CTL_IDX       8'h00
`define SCCR_CNF_IDX       8'h02

// Control bits
`define SCCR_CTL_PAGE      0
`define SCCR_CTL_ABORT     1
`define SCCR_CTL_KILL      2
`define SCCR_CTL_LDC       3
`define SCCR_CTL_LDCF      4
`define SCCR_CTL_RSTD      5
`define SCCR_CTL_FCLR      6

// Configuration bits
`define SCCR_CNF_BCHK      0
`define SCCR_CNF_LLBC      1
`define SCCR_CNF_PAR       2
`define SCCR_CNF_PUE       3
`define SCCR_CNF_RFM       4
`define SCCR_CNF_DIV_LO    5
`define SCCR_CNF_DIV_HI    7

// Setup (own) register bits
`define SCCR_SET_BCHKF     0
`define SCCR_SET_UEMASK    1

// Status register bits
`define SCCR_STS_UEI       0
`define SCCR_STS_UEPEND    1
`define SCCR_STS_LAST      2
`define SCCR_STS_BUSY      3
`define SCCR_STS_RSTIRQ    4

// Reset values
`define SCCR_CTL_RST       8'h00
`define SCCR_CNF_RST       8'hA0
`define SCCR_SET_RST       8'h00

// Timebase divider codes and counts
`define SCCR_DIV_20        3'h2
`define SCCR_DIV_30        3'h3
`define SCCR_DIV_40        3'h4
`define SCCR_DIV_DEF       3'h5
`define SCCR_TB_NS         100
`define SCCR_CLK_NS        10
`define SCCR_TB_CYC        ((`SCCR_TB_NS + `SCCR_CLK_NS - 1) / `SCCR_CLK_NS)

`endif

// ==== common/sccr_pkg.sv ====
/*
  Types of the SCSI control and configuration register bank.
  Assumes sccr_cfg.svh is on the include path.
*/
`include "sccr_cfg.svh"

package sccr_pkg;

  // Command pulses to the SCSI datapath
  typedef struct packed {
    logic fifo_clear;
    logic fifo_flush;
    logic halt_now;
    logic halt_clean;
    logic seq_stop;
    logic count_load;
    logic count_final;
    logic setup_reset;
  } sccr_cmd_t;

  // Static configuration to the SCSI pads and datapath
  typedef struct packed {
    logic       bus_rst_o;
    logic       outs_disable;
    logic       pullup_enable;
    logic       active_negation;
    logic       parity_check;
    logic       parity_sel_check;
    logic       low_level_bus_control;
    logic       block_check;
  } sccr_drv_t;

  typedef enum logic [1:0] {
    SCCR_IDLE,
    SCCR_ACK
  } sccr_bus_st_t;

  typedef struct packed {
    sccr_bus_st_t bst;
    logic [7:0]   ctl;
    logic [7:0]   cnf;
    logic [7:0]   setr;
    logic [31:0]  rdat;
    logic         ack;
    logic         unexpected_event_irq;
    logic         uepend;
    logic         last;
    logic         busy;
    logic         final_pend;
    logic         reset_follower_pin;
    logic [2:0]   tbcnt;
    logic         tick;
    sccr_cmd_t    cmd;
    sccr_drv_t    drv;
  } sccr_state_t;

endpackage

// ==== rtl/sccr_top.sv ====
/*
  SCSI bus control and configuration register bank with a classic
  Wishbone slave, command pulses, driver controls and timebase tick.
  Assumes a single 100 MHz clock, synchronous reset, and that the
  datapath reports transfer completion and the bus-reset status bit.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sccr_cfg.svh"

module sccr_top (
  // Clock, reset, enable
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Datapath status
  input  wire logic               xfer_done_i,
  input  wire logic               unexp_event_i,
  input  wire logic               bus_reset_irq_flag_i,
  input  wire logic               high_drive_select_i,
  input  wire logic               single_ended_select_i,
  // Datapath controls
  output sccr_pkg::sccr_cmd_t     cmd_o,
  output sccr_pkg::sccr_drv_t     drv_o,
  output logic                    setup_page_o,
  output logic                    reset_follower_pin_o,
  output logic                    timebase_tick_o
);
  import sccr_pkg::*;

  sccr_state_t s_r;
  sccr_state_t s_nxt;
  logic        wr;
  logic        rd;
  logic        hit_ctl;
  logic        hit_cnf;
  logic        hit_sts;
  logic        hit_set;
  logic [7:0]  wd;
  logic [2:0]  div;
  logic [2:0]  div_m1;

  always_comb begin
    s_nxt   = s_r;
    wd      = wb_dat_i[7:0];
    // Control sits at the same address on both pages
    hit_ctl = (wb_adr_i == `SCCR_CTL_ADDR);
    hit_cnf = (wb_adr_i == `SCCR_CNF_ADDR) && s_r.ctl[`SCCR_CTL_PAGE];
    hit_set = (wb_adr_i == `SCCR_SET_ADDR) && s_r.ctl[`SCCR_CTL_PAGE];
    hit_sts = (wb_adr_i == `SCCR_STS_ADDR);
    wr      = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
              && (s_r.bst == SCCR_IDLE);
    rd      = wb_cyc_i && wb_stb_i && !wb_we_i && (s_r.bst == SCCR_IDLE);
    div     = s_r.cnf[`SCCR_CNF_DIV_HI:`SCCR_CNF_DIV_LO];
    // Unlisted codes fall back to the default divide
    if (div < `SCCR_DIV_20 || div > `SCCR_DIV_DEF) begin
      div = `SCCR_DIV_DEF;
    end
    div_m1  = div - 3'h1;

    // Commands are single-cycle pulses
    s_nxt.cmd = '0;

    // Bus slave: ack one cycle after request, drop next cycle
    case (s_r.bst)
      SCCR_IDLE: begin
        s_nxt.ack = 1'b0;
        if (wb_cyc_i && wb_stb_i) begin
          s_nxt.ack = 1'b1;
          s_nxt.bst = SCCR_ACK;
        end
      end
      SCCR_ACK: begin
        s_nxt.ack = 1'b0;
        s_nxt.bst = SCCR_IDLE;
      end
      default: begin
        s_nxt.ack = 1'b0;
        s_nxt.bst = SCCR_IDLE;
      end
    endcase

    if (rd) begin
      s_nxt.rdat = 32'h0000_0000;
      if (hit_ctl) begin
        s_nxt.rdat[7:0] = s_r.ctl;
      end else if (hit_cnf) begin
        s_nxt.rdat[7:0] = s_r.cnf;
      end else if (hit_set) begin
        s_nxt.rdat[7:0] = s_r.setr;
      end else if (hit_sts) begin
        s_nxt.rdat[`SCCR_STS_UEI]    = s_r.unexpected_event_irq;
        s_nxt.rdat[`SCCR_STS_UEPEND] = s_r.uepend;
        s_nxt.rdat[`SCCR_STS_LAST]   = s_r.last;
        s_nxt.rdat[`SCCR_STS_BUSY]   = s_r.busy;
        s_nxt.rdat[`SCCR_STS_RSTIRQ] = bus_reset_irq_flag_i;
      end
    end

    // Completion is taken even when a control write lands with it
    if (xfer_done_i && s_r.busy) begin
      s_nxt.busy = 1'b0;
      if (s_r.final_pend) begin
        s_nxt.last = 1'b1;
      end
    end
    if (wr && hit_ctl) begin
      // Only page and bus-reset drive are held; the rest are pulses
      s_nxt.ctl = wd & ((8'h01 << `SCCR_CTL_PAGE) | (8'h01 << `SCCR_CTL_RSTD));
      // Falling bus-reset drive sets the unexpected-event pending bit
      if (s_r.ctl[`SCCR_CTL_RSTD] && !wd[`SCCR_CTL_RSTD]) begin
        s_nxt.uepend = 1'b1;
      end
      s_nxt.cmd.fifo_clear = wd[`SCCR_CTL_FCLR] | wd[`SCCR_CTL_KILL];
      if (wd[`SCCR_CTL_KILL]) begin
        s_nxt.cmd.halt_now = 1'b1;
        s_nxt.cmd.seq_stop = 1'b1;
        s_nxt.busy         = 1'b0;
      end else if (wd[`SCCR_CTL_ABORT]) begin
        s_nxt.cmd.halt_clean = 1'b1;
        s_nxt.cmd.fifo_flush = 1'b1;
        s_nxt.cmd.seq_stop   = 1'b1;
        s_nxt.busy           = 1'b0;
      end
      if (wd[`SCCR_CTL_LDC] && wd[`SCCR_CTL_LDCF]) begin
        s_nxt.cmd.setup_reset = 1'b1;
        s_nxt.busy            = 1'b0;
        s_nxt.final_pend      = 1'b0;
      end else if (wd[`SCCR_CTL_LDCF]) begin
        s_nxt.cmd.count_load  = 1'b1;
        s_nxt.cmd.count_final = 1'b1;
        s_nxt.busy            = 1'b1;
        s_nxt.final_pend      = 1'b1;
      end else if (wd[`SCCR_CTL_LDC]) begin
        s_nxt.cmd.count_load  = 1'b1;
        s_nxt.busy            = 1'b1;
        s_nxt.final_pend      = 1'b0;
      end
    end

    if (wr && hit_cnf) begin
      s_nxt.cnf = wd;
    end
    if (wr && hit_set) begin
      s_nxt.setr = wd & 8'h03;
    end

    // Unexpected events; pending stays until written with one and raises UEI once the mask is open
    if (unexp_event_i) begin
      s_nxt.uepend = 1'b1;
    end
    if (s_r.uepend && s_r.setr[`SCCR_SET_UEMASK]) begin
      s_nxt.unexpected_event_irq = 1'b1;
    end
    // Writing one to the UEI, pending and last bits clears them; a new set wins
    if (wr && hit_sts) begin
      if (wd[`SCCR_STS_UEI] && !(s_r.uepend && s_r.setr[`SCCR_SET_UEMASK])) begin
        s_nxt.unexpected_event_irq = 1'b0;
      end
      if (wd[`SCCR_STS_UEPEND] && !unexp_event_i) begin
        s_nxt.uepend = 1'b0;
      end
      if (wd[`SCCR_STS_LAST] && !(xfer_done_i && s_r.busy && s_r.final_pend)) begin
        s_nxt.last = 1'b0;
      end
    end

    // Reset follower pin
    s_nxt.reset_follower_pin = s_r.cnf[`SCCR_CNF_RFM] & bus_reset_irq_flag_i;

    // Timebase tick
    s_nxt.tick = 1'b0;
    if (s_r.tbcnt >= div_m1) begin
      s_nxt.tbcnt = 3'h0;
      s_nxt.tick  = 1'b1;
    end else begin
      s_nxt.tbcnt = s_r.tbcnt + 3'h1;
    end

    // Pad and datapath controls
    s_nxt.drv.bus_rst_o    = s_nxt.ctl[`SCCR_CTL_RSTD];
    s_nxt.drv.outs_disable = s_nxt.ctl[`SCCR_CTL_RSTD];
    s_nxt.drv.pullup_enable   = s_nxt.cnf[`SCCR_CNF_PUE];
    s_nxt.drv.active_negation = s_nxt.cnf[`SCCR_CNF_PUE]
                                & high_drive_select_i
                                & single_ended_select_i;
    s_nxt.drv.parity_check     = s_nxt.cnf[`SCCR_CNF_PAR];
    s_nxt.drv.parity_sel_check = s_nxt.cnf[`SCCR_CNF_PAR];
    s_nxt.drv.low_level_bus_control = s_nxt.cnf[`SCCR_CNF_LLBC];
    s_nxt.drv.block_check = s_nxt.cnf[`SCCR_CNF_BCHK]
                            & s_nxt.setr[`SCCR_SET_BCHKF];

    if (rst_i) begin
      s_nxt      = '0;
      s_nxt.bst  = SCCR_IDLE;
      s_nxt.ctl  = `SCCR_CTL_RST;
      s_nxt.cnf  = `SCCR_CNF_RST;
      s_nxt.setr = `SCCR_SET_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i || rst_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o             = s_r.rdat;
  assign wb_ack_o             = s_r.ack;
  assign cmd_o                = s_r.cmd;
  assign drv_o                = s_r.drv;
  assign setup_page_o         = s_r.ctl[`SCCR_CTL_PAGE];
  assign reset_follower_pin_o = s_r.reset_follower_pin;
  assign timebase_tick_o      = s_r.tick;

endmodule

`default_nettype wire

// ==== verification/sccr_top_asserts.sv ====
/*
  Port checker of the SCSI control register bank.
  Assumes binding to sccr_top by the bench top file.
*/
`timescale 1ns/1ps
`default_nettype none
module sccr_top_chk (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [7:0]          wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic                wb_ack_o,
  input wire logic                bus_reset_irq_flag_i,
  input wire sccr_pkg::sccr_cmd_t cmd_o,
  input wire sccr_pkg::sccr_drv_t drv_o,
  input wire logic                reset_follower_pin_o,
  input wire logic                timebase_tick_o
);
  import sccr_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  a_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ctl_load: assert property (req && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == 8'h00 && wb_dat_i[4:3] == 2'b01
    |=> cmd_o.count_load && !cmd_o.setup_reset)
    else $error("load pulse missing");
  a_both_loads: assert property (cmd_o.setup_reset |->
    !cmd_o.count_load && !cmd_o.count_final) else $error("both loads");
  a_kill_reset: assert property (cmd_o.halt_now |->
    cmd_o.fifo_clear && cmd_o.seq_stop && !cmd_o.fifo_flush)
    else $error("kill set wrong");
  a_abort_clean: assert property (cmd_o.halt_clean |->
    cmd_o.fifo_flush && cmd_o.seq_stop) else $error("abort set wrong");
  a_cmd_oneshot: assert property (|cmd_o |=> cmd_o == '0)
    else $error("command held");
  a_rst_disable: assert property (drv_o.bus_rst_o |->
    drv_o.outs_disable) else $error("outputs live in reset");
  a_follow_off: assert property (!$past(bus_reset_irq_flag_i)
    |-> !reset_follower_pin_o) else $error("follower without flag");
  a_tick_gap: assert property (timebase_tick_o |=>
    !timebase_tick_o) else $error("tick too close");
endmodule
`default_nettype wire

// ==== verification/sccr_scsi_model.sv ====
/*
  Far side of the bank: transfer engine and bus reset status.
  Assumes the bank's command pulses and driver levels as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module sccr_scsi_model (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire sccr_pkg::sccr_cmd_t cmd_i,
  input  wire sccr_pkg::sccr_drv_t drv_i,
  output logic                     done_o,
  output logic                     event_o,
  output logic                     flag_o
);
  import sccr_pkg::*;
  logic [2:0] wait_r;
  logic       seen_r;
  initial {wait_r, seen_r, done_o, event_o, flag_o} = '0;
  always @(posedge clk_i) begin
    if (rst_i) begin
      {wait_r, seen_r, done_o, event_o, flag_o} <= '0;
    end else begin
      done_o <= (wait_r == 3'h1);
      event_o <= seen_r & ~drv_i.bus_rst_o;
      seen_r <= drv_i.bus_rst_o;
      flag_o <= flag_o | drv_i.bus_rst_o;
      if (cmd_i.halt_now | cmd_i.halt_clean | cmd_i.setup_reset) begin
        wait_r <= 3'h0;
      end else if (cmd_i.count_load | cmd_i.count_final) begin
        wait_r <= 3'h3;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_sccr_top.sv ====
/*
  Bench of the SCSI control register bank over Wishbone.
  Assumes sccr_top, the far side model and the checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_sccr_top;
  import sccr_pkg::*;
  logic        clk_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        wb_cyc_i = 1'h0;
  logic        wb_stb_i = 1'h0;
  logic        wb_we_i = 1'h0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic        hd = 1'h1;
  logic        se = 1'h1;
  logic        ce = 1'h1;
  logic        wb_ack_o, done, evt, rflag, page, pin, tick;
  logic [31:0] wb_dat_o, rdat;
  sccr_cmd_t   cmd, cmd_seen;
  sccr_drv_t   drv;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  logic [7:0]  wv [7] = '{8'h43, 8'h05, 8'h03, 8'h07, 8'h09, 8'h11, 8'h19};
  logic [7:0]  ev [7] = '{8'hD8, 8'hA8, 8'h58, 8'hA8, 8'h04, 8'h06, 8'h01};
  always #5 clk_i = ~clk_i;
  sccr_top dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .xfer_done_i(done), .unexp_event_i(evt), .bus_reset_irq_flag_i(rflag),
    .high_drive_select_i(hd), .single_ended_select_i(se), .cmd_o(cmd),
    .drv_o(drv), .setup_page_o(page), .reset_follower_pin_o(pin),
    .timebase_tick_o(tick));
  sccr_scsi_model far (.clk_i, .rst_i, .cmd_i(cmd), .drv_i(drv),
    .done_o(done), .event_o(evt), .flag_o(rflag));
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, msk);
    tests_run++;
    if ((got & msk) !== (exp & msk)) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, d);
    int t;
    t = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, a};
    {wb_sel_i, wb_dat_i} <= {4'hF, 24'h00_0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1 && ++t < 20);
    chk(t < 20, 1'h1, 1'h1);
    rdat = wb_dat_o;
    cmd_seen = cmd;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask
  task automatic gap(input int n);
    int c;
    c = 0;
    @(posedge clk_i iff tick === 1'h1);
    do begin
      @(posedge clk_i);
      c++;
    end while (tick !== 1'h1 && c < 9);
    chk(c, n, 32'h0000_00FF);
  endtask
  always @(posedge clk_i) begin
    if (++cyc_n == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(0, 8'h04, 8'h00);
    chk(rdat, 0, 32'hFFFF_FFFF);
    acc(1, 8'h00, 8'h01);
    acc(0, 8'h00, 8'h00);
    chk(rdat, 32'h0000_0001, 32'hFFFF_FFFF);
    chk(page, 1'h1, 1'h1);
    acc(0, 8'h04, 8'h00);
    chk(rdat, 32'h0000_00A0, 32'hFFFF_FFFF);
    acc(0, 8'h10, 8'h00);
    chk(rdat, 0, 32'hFFFF_FFFF);
    $display("test access done");
    for (int i = 0; i < 7; i++) begin
      acc(1, 8'h00, wv[i]);
      chk(cmd_seen, ev[i], 8'hFF);
      repeat (4) @(posedge clk_i);
      acc(0, 8'h08, 8'h00);
      if (i < 6) chk(rdat, (i == 5) ? 4 : 0, 8'h04);
    end
    acc(0, 8'h00, 8'h00);
    chk(rdat, 8'h01, 8'hFF);
    $display("test commands done");
    acc(1, 8'h04, 8'hB0);
    acc(1, 8'h00, 8'h21);
    repeat (3) @(posedge clk_i);
    chk(drv, 8'hC0, 8'hC0);
    chk(pin, 1'h1, 1'h1);
    acc(1, 8'h00, 8'h01);
    acc(0, 8'h08, 8'h00);
    chk(rdat, 0, 8'h01);
    acc(1, 8'h0C, 8'h02);
    acc(0, 8'h08, 8'h00);
    chk(rdat, 8'h11, 8'h11);
    acc(1, 8'h04, 8'hA0);
    repeat (3) @(posedge clk_i);
    chk(pin, 1'h0, 1'h1);
    $display("test bus reset done");
    acc(1, 8'h0C, 8'h00);
    acc(1, 8'h04, 8'hAF);
    repeat (3) @(posedge clk_i);
    chk(drv, 8'h3A, 8'hFB);
    acc(1, 8'h0C, 8'h01);
    repeat (3) @(posedge clk_i);
    chk(drv, 8'h3B, 8'hFB);
    se <= 1'h0;
    acc(1, 8'h04, 8'hA8);
    repeat (3) @(posedge clk_i);
    chk(drv, 8'h20, 8'hFB);
    $display("test config done");
    for (int c = 0; c < 8; c++) begin
      acc(1, 8'h04, {c[2:0], 5'h00});
      gap((c < 2 || c > 5) ? 5 : c);
    end
    $display("test timebase done");
    @(posedge clk_i iff tick === 1'h1);
    ce <= 1'h0;
    rdat = 32'h0000_0000;
    repeat (12) begin
      @(posedge clk_i);
      rdat = rdat + tick;
    end
    chk(rdat, 0, 32'hFFFF_FFFF);
    ce <= 1'h1;
    rdat = 32'h0000_0000;
    do begin
      @(posedge clk_i);
      rdat = rdat + 1;
    end while (tick !== 1'h1 && rdat < 9);
    chk(rdat, 5, 32'hFFFF_FFFF);
    $display("test clock enable done");
    summarize();
  end
endmodule
bind sccr_top sccr_top_chk u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o,
  .bus_reset_irq_flag_i, .cmd_o, .drv_o, .reset_follower_pin_o,
  .timebase_tick_o);
`default_nettype wire
